// File: pss_ahb_port.sv
// AHB-Lite slave front end for the sequencer's register file
`timescale 1ns/1ns
`default_nettype none
module pss_ahb_port (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Register side
  output logic [7:0]       reg_addr,
  output logic             reg_wr,
  input  wire logic [31:0] reg_rdata
);
  logic dp_rd_r;
  logic dp_wr_r;
  logic accept;

  assign accept = hsel & hready & (htrans == pss_pkg::HTRANS_NSEQ);
  assign reg_wr = dp_wr_r & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd_r  <= 1'b0;
      dp_wr_r  <= 1'b0;
      reg_addr <= 8'h00;
    end else if (accept) begin
      dp_rd_r  <= ~hwrite;
      // Only whole words are written; narrower writes are dropped
      dp_wr_r  <= hwrite & (hsize == pss_pkg::HSIZE_WORD);
      reg_addr <= haddr[7:0];
    end else if (hready) begin
      dp_rd_r  <= 1'b0;
      dp_wr_r  <= 1'b0;
    end
  end

  // Reads take one wait state so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (accept && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (dp_rd_r && !hreadyout) begin
      hrdata    <= reg_rdata;
      hreadyout <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: pss_mem_model.sv
// Word-wide system memory model for the sequencer
`timescale 1ns/1ns
`default_nettype none
module pss_mem_model (
  // Clock, reset, stall and fault address
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  slow,
  input  wire logic [31:0]           bad_addr,
  // Sequencer side
  input  wire pss_pkg::pss_mem_req_t req,
  output pss_pkg::pss_mem_rsp_t      rsp
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_r;
  logic        hit;
  assign hit = req.valid && !rsp.ack && wait_r >= {slow, 1'b0};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp <= '0;
      wait_r <= 2'h0;
    end else begin
      rsp.ack <= hit;
      rsp.fault <= hit && req.addr == bad_addr;
      // Idle data toggles so a stale word never passes as an answer
      if (hit && !req.write && mem.exists(req.addr))
        rsp.rdata <= mem[req.addr];
      else
        rsp.rdata <= ~rsp.rdata;
      if (hit && req.write && req.addr != bad_addr)
        mem[req.addr] = req.wdata;
      wait_r <= (hit || rsp.ack || !req.valid) ? 2'h0 : wait_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: pss_mem_port.sv
// Single-outstanding memory request holder
`timescale 1ns/1ns
`default_nettype none
module pss_mem_port (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Sequencer side
  input  wire logic                  start,
  input  wire pss_pkg::pss_mem_req_t cmd,
  output logic                       done,
  output logic                       fault,
  output logic [31:0]                rdata,
  // Memory side
  output pss_pkg::pss_mem_req_t      req,
  input  wire pss_pkg::pss_mem_rsp_t rsp
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req   <= '0;
      done  <= 1'b0;
      fault <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      if (req.valid && rsp.ack) begin
        req.valid <= 1'b0;
        done      <= 1'b1;
        fault     <= rsp.fault;
        rdata     <= rsp.rdata;
      end else if (start && !req.valid) begin
        req       <= cmd;
        req.valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: pss_pkg.sv
// Shared constants and types for the process switch sequencer
package pss_pkg;
  localparam logic [7:0]  REG_SPAN    = 8'h40;
  localparam logic [7:0]  ADDR_CTRL   = 8'h40;
  localparam logic [7:0]  ADDR_STAT   = 8'h44;
  localparam int unsigned CTRL_CALL   = 0;
  localparam int unsigned CTRL_RET    = 1;
  localparam logic [3:0]  IDX_R0      = 4'h0;
  localparam logic [3:0]  IDX_R1      = 4'h1;
  localparam logic [3:0]  IDX_R2      = 4'h2;
  localparam logic [3:0]  IDX_R10     = 4'ha;
  localparam logic [3:0]  IDX_PSW     = 4'hb;
  localparam logic [3:0]  IDX_PC      = 4'hc;
  localparam logic [3:0]  IDX_SP      = 4'hd;
  localparam logic [3:0]  IDX_CONTROL_BLOCK_POINTER    = 4'he;
  localparam logic [3:0]  IDX_ISP     = 4'hf;
  // Status word layout
  localparam int unsigned ET_LSB      = 0;
  localparam int unsigned TM_BIT      = 2;
  localparam int unsigned ISC_LSB     = 3;
  localparam int unsigned I_BIT       = 7;
  localparam int unsigned R_BIT       = 8;
  localparam int unsigned CM_LSB      = 9;
  localparam logic [1:0]  CM_KERNEL   = 2'h0;
  localparam logic [3:0]  ISC_SAVE    = 4'h0;
  localparam logic [3:0]  ISC_LOAD    = 4'h7;
  localparam logic [1:0]  ET_SAVE     = 2'h1;
  localparam logic [1:0]  ET_LOAD     = 2'h3;
  localparam logic        TM_CLEAR    = 1'b0;
  // Step sizes, control block byte offsets and bus codes
  localparam logic [31:0] PC_STEP     = 32'h2;
  localparam logic [31:0] WORD_BYTES  = 32'h4;
  localparam logic [31:0] PC_OFF      = 32'h4;
  localparam logic [31:0] SP_OFF      = 32'h8;
  localparam logic [31:0] CTX_BYTES   = 32'hc;
  localparam logic [31:0] GR_OFF      = 32'h14;
  localparam logic [31:0] BMA_OFF     = 32'h40;
  localparam logic [31:0] BM_ENTRY    = 32'hc;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;

  typedef enum logic [2:0] {
    EXC_NONE     = 3'h0,
    EXC_RST_ISTK = 3'h1,
    EXC_OLD_PCB  = 3'h2,
    EXC_NEW_PCB  = 3'h3,
    EXC_PRIV     = 3'h4
  } pss_exc_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        kernel;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pss_mem_req_t;

  typedef struct packed {
    logic        ack;
    logic        fault;
    logic [31:0] rdata;
  } pss_mem_rsp_t;
endpackage

// File: pss_switch_seq.sv
// Process switch sequencer: call and return-to-process microsequences
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Copy r0 to temp, force kernel
// - Push old pointer; fault is stack reset
// - Advance program counter by two first
// - Copy incoming register save flag
// - Store status with fields 0,0,1
// - Save pc, sp; registers if flagged
// - Old block write fault is reported
// - Load pointer, status (trace 0), pc, sp
// - Initial flag cleared, pointer moved
// - Initial adjustment is twelve bytes
// - New block read fault is reported
// - Live status fields set 7,0,3
// - Block moves preload r0, r1, r2
// - Release forced kernel at end
// - Return outside kernel is privileged fault
// - Return pops pointer; fault is reset
// - Return copies register save flag
// - Return saves nothing of exiting process
// - Return restores without initial adjustment
// - Return reloads r0..r10 after moves
// - Full interrupt path is a process switch
// - No interrupt accepted during a switch
// - Push adds four, pop subtracts four
module pss_switch_seq (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // System memory
  output pss_pkg::pss_mem_req_t      mem_req,
  input  wire pss_pkg::pss_mem_rsp_t mem_rsp,
  // Status to the core
  output logic                       switch_busy,
  output logic                       exc_valid,
  output pss_pkg::pss_exc_t          exc_code
);
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h00,
    ST_PUSH   = 5'h01,
    ST_RDR    = 5'h03,
    ST_SV_PSW = 5'h02,
    ST_SV_PC  = 5'h06,
    ST_SV_SP  = 5'h07,
    ST_SV_GR  = 5'h05,
    ST_LD_PSW = 5'h04,
    ST_LD_PC  = 5'h0c,
    ST_LD_SP  = 5'h0d,
    ST_BM_CNT = 5'h0f,
    ST_BM_SRC = 5'h0e,
    ST_BM_DST = 5'h0a,
    ST_BM_RD  = 5'h0b,
    ST_BM_WR  = 5'h09,
    ST_DONE   = 5'h08,
    ST_POP    = 5'h18,
    ST_RS_GR  = 5'h19
  } pss_state_t;

  function automatic logic [31:0] word_at(
    input logic [31:0] base,
    input logic [3:0]  idx
  );
    word_at = base + {26'h0, idx, 2'h0};
  endfunction

  function automatic logic [31:0] set_fields(
    input logic [31:0] processor_status_word,
    input logic [3:0]  internal_state_code,
    input logic [1:0]  et
  );
    logic [31:0] v;
    v = processor_status_word;
    v[pss_pkg::ISC_LSB +: 4] = internal_state_code;
    v[pss_pkg::TM_BIT]       = pss_pkg::TM_CLEAR;
    v[pss_pkg::ET_LSB +: 2]  = et;
    set_fields = v;
  endfunction

  pss_state_t  state_r;
  logic [31:0] regs_r [16];
  logic [31:0] tempa_r;
  logic [31:0] bm_ptr_r;
  logic [31:0] mv_data_r;
  logic [3:0]  gr_idx_r;
  logic        is_ret_r;
  logic        issued_r;
  logic        force_kernel_r;

  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [31:0] reg_rdata;
  logic        mp_start;
  logic        mp_done;
  logic        mp_fault;
  logic [31:0] mp_rdata;
  logic        fin;
  logic        ok;
  logic        bus_ok;
  logic        r_set;
  logic        kernel_now;
  logic        go_call;
  logic        go_ret;
  pss_pkg::pss_mem_req_t acc;

  assign r_set      = regs_r[pss_pkg::IDX_PSW][pss_pkg::R_BIT];
  assign kernel_now = regs_r[pss_pkg::IDX_PSW][pss_pkg::CM_LSB +: 2]
                      == pss_pkg::CM_KERNEL;
  assign fin        = mp_done & ~mp_fault;
  assign ok         = fin;
  // Software cannot disturb state mid-switch
  assign bus_ok     = reg_wr & ~switch_busy;
  assign go_call    = bus_ok & (reg_addr == pss_pkg::ADDR_CTRL)
                      & hwdata[pss_pkg::CTRL_CALL];
  assign go_ret     = bus_ok & (reg_addr == pss_pkg::ADDR_CTRL)
                      & hwdata[pss_pkg::CTRL_RET]
                      & ~hwdata[pss_pkg::CTRL_CALL];
  assign mp_start   = (state_r != ST_IDLE) & (state_r != ST_DONE)
                      & ~issued_r;

  pss_ahb_port u_ahb (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rdata (reg_rdata)
  );

  pss_mem_port u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (mp_start),
    .cmd     (acc),
    .done    (mp_done),
    .fault   (mp_fault),
    .rdata   (mp_rdata),
    .req     (mem_req),
    .rsp     (mem_rsp)
  );

  // Readback; the temp pointer has no address
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (reg_addr < pss_pkg::REG_SPAN) begin
      reg_rdata = regs_r[reg_addr[5:2]];
    end else if (reg_addr == pss_pkg::ADDR_STAT) begin
      reg_rdata = {27'h0, exc_code, force_kernel_r, switch_busy};
    end
  end

  // Address and data of each memory step
  always_comb begin
    acc        = '0;
    acc.kernel = force_kernel_r;
    case (state_r)
      ST_PUSH: begin
        acc.write = 1'b1;
        acc.addr  = regs_r[pss_pkg::IDX_ISP];
        acc.wdata = regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER];
      end
      ST_POP: begin
        acc.addr = regs_r[pss_pkg::IDX_ISP]
                   - pss_pkg::WORD_BYTES;
      end
      ST_RDR: begin
        acc.addr = tempa_r;
      end
      ST_SV_PSW: begin
        acc.write = 1'b1;
        acc.addr  = regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER];
        acc.wdata = set_fields(regs_r[pss_pkg::IDX_PSW],
                               pss_pkg::ISC_SAVE,
                               pss_pkg::ET_SAVE);
      end
      ST_SV_PC: begin
        acc.write = 1'b1;
        acc.addr  = regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER] + pss_pkg::PC_OFF;
        acc.wdata = regs_r[pss_pkg::IDX_PC];
      end
      ST_SV_SP: begin
        acc.write = 1'b1;
        acc.addr  = regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER] + pss_pkg::SP_OFF;
        acc.wdata = regs_r[pss_pkg::IDX_SP];
      end
      ST_SV_GR: begin
        acc.write = 1'b1;
        acc.addr  = word_at(regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER]
                            + pss_pkg::GR_OFF, gr_idx_r);
        acc.wdata = regs_r[gr_idx_r];
      end
      ST_LD_PSW: acc.addr = tempa_r;
      ST_LD_PC:  acc.addr = tempa_r + pss_pkg::PC_OFF;
      ST_LD_SP:  acc.addr = tempa_r + pss_pkg::SP_OFF;
      ST_BM_CNT: acc.addr = bm_ptr_r;
      ST_BM_SRC: acc.addr = bm_ptr_r + pss_pkg::PC_OFF;
      ST_BM_DST: acc.addr = bm_ptr_r + pss_pkg::SP_OFF;
      ST_BM_RD:  acc.addr = regs_r[pss_pkg::IDX_R0];
      ST_BM_WR: begin
        acc.write = 1'b1;
        acc.addr  = regs_r[pss_pkg::IDX_R2];
        acc.wdata = mv_data_r;
      end
      ST_RS_GR: begin
        acc.addr = word_at(regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER]
                           + pss_pkg::GR_OFF, gr_idx_r);
      end
      default: acc.addr = 32'h0000_0000;
    endcase
  end

  // One request per step; cleared when its answer lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      issued_r <= 1'b0;
    end else if (mp_done) begin
      issued_r <= 1'b0;
    end else if (mp_start) begin
      issued_r <= 1'b1;
    end
  end

  // Step sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go_call && kernel_now) begin
            state_r <= ST_PUSH;
          end else if (go_ret && kernel_now) begin
            state_r <= ST_POP;
          end
        end
        ST_PUSH:   if (mp_done) state_r <= ok ? ST_RDR : ST_DONE;
        ST_POP:    if (mp_done) state_r <= ok ? ST_RDR : ST_DONE;
        ST_RDR: begin
          if (mp_done) begin
            // Return skips every save step
            state_r <= !ok ? ST_DONE :
                       is_ret_r ? ST_LD_PSW : ST_SV_PSW;
          end
        end
        ST_SV_PSW: if (mp_done) state_r <= ok ? ST_SV_PC : ST_DONE;
        ST_SV_PC:  if (mp_done) state_r <= ok ? ST_SV_SP : ST_DONE;
        ST_SV_SP: begin
          if (mp_done) begin
            state_r <= !ok ? ST_DONE :
                       r_set ? ST_SV_GR : ST_LD_PSW;
          end
        end
        ST_SV_GR: begin
          if (mp_done) begin
            state_r <= !ok ? ST_DONE :
                       (gr_idx_r == pss_pkg::IDX_R10) ? ST_LD_PSW
                                                      : ST_SV_GR;
          end
        end
        ST_LD_PSW: if (mp_done) state_r <= ok ? ST_LD_PC : ST_DONE;
        ST_LD_PC:  if (mp_done) state_r <= ok ? ST_LD_SP : ST_DONE;
        ST_LD_SP: begin
          if (mp_done) begin
            state_r <= !ok ? ST_DONE :
                       r_set ? ST_BM_CNT : ST_DONE;
          end
        end
        ST_BM_CNT: begin
          if (mp_done) begin
            if (!ok) begin
              state_r <= ST_DONE;
            end else if (mp_rdata != 32'h0000_0000) begin
              state_r <= ST_BM_SRC;
            end else begin
              state_r <= is_ret_r ? ST_RS_GR : ST_DONE;
            end
          end
        end
        ST_BM_SRC: if (mp_done) state_r <= ok ? ST_BM_DST : ST_DONE;
        ST_BM_DST: if (mp_done) state_r <= ok ? ST_BM_RD : ST_DONE;
        ST_BM_RD:  if (mp_done) state_r <= ok ? ST_BM_WR : ST_DONE;
        ST_BM_WR: begin
          if (mp_done) begin
            state_r <= !ok ? ST_DONE :
                       (regs_r[pss_pkg::IDX_R1] == 32'h1) ? ST_BM_CNT
                                                          : ST_BM_RD;
          end
        end
        ST_RS_GR: begin
          if (mp_done) begin
            state_r <= !ok ? ST_DONE :
                       (gr_idx_r == pss_pkg::IDX_R10) ? ST_DONE
                                                      : ST_RS_GR;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Sequence bookkeeping: kind, temp pointer, counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      is_ret_r  <= 1'b0;
      tempa_r   <= 32'h0000_0000;
      gr_idx_r  <= 4'h0;
      bm_ptr_r  <= 32'h0000_0000;
      mv_data_r <= 32'h0000_0000;
    end else begin
      if (state_r == ST_IDLE) begin
        is_ret_r <= go_ret;
        gr_idx_r <= pss_pkg::IDX_R0;
        if (go_call) begin
          tempa_r <= regs_r[pss_pkg::IDX_R0];
        end
      end
      if (state_r == ST_POP && fin) begin
        tempa_r <= mp_rdata;
      end
      if ((state_r == ST_SV_GR || state_r == ST_RS_GR) && fin) begin
        gr_idx_r <= gr_idx_r + 4'h1;
      end
      if (state_r == ST_SV_SP) begin
        gr_idx_r <= pss_pkg::IDX_R0;
      end
      if (state_r == ST_BM_CNT && fin) begin
        gr_idx_r <= pss_pkg::IDX_R0;
      end
      // Step to the next entry only after src and dst are read
      if (state_r == ST_BM_DST && fin) begin
        bm_ptr_r <= bm_ptr_r + pss_pkg::BM_ENTRY;
      end
      if (state_r == ST_LD_SP && fin) begin
        // Block-move list follows the live pointer
        bm_ptr_r <= (!is_ret_r && regs_r[pss_pkg::IDX_PSW][pss_pkg::I_BIT])
                    ? tempa_r + pss_pkg::CTX_BYTES + pss_pkg::BMA_OFF
                    : tempa_r + pss_pkg::BMA_OFF;
      end
      if (state_r == ST_BM_RD && fin) begin
        mv_data_r <= mp_rdata;
      end
    end
  end

  // Architectural registers: bus writes only while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) begin
        regs_r[i] <= 32'h0000_0000;
      end
    end else begin
      if (bus_ok && reg_addr < pss_pkg::REG_SPAN) begin
        regs_r[reg_addr[5:2]] <= hwdata;
      end
      case (state_r)
        ST_PUSH: begin
          if (fin) begin
            regs_r[pss_pkg::IDX_ISP] <= regs_r[pss_pkg::IDX_ISP]
                                        + pss_pkg::WORD_BYTES;
            regs_r[pss_pkg::IDX_PC] <= regs_r[pss_pkg::IDX_PC]
                                       + pss_pkg::PC_STEP;
          end
        end
        ST_POP: begin
          if (fin) begin
            regs_r[pss_pkg::IDX_ISP] <= regs_r[pss_pkg::IDX_ISP]
                                        - pss_pkg::WORD_BYTES;
          end
        end
        ST_RDR: begin
          if (fin) begin
            regs_r[pss_pkg::IDX_PSW][pss_pkg::R_BIT] <=
              mp_rdata[pss_pkg::R_BIT];
          end
        end
        ST_LD_PSW: begin
          if (fin) begin
            regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER] <= tempa_r;
            regs_r[pss_pkg::IDX_PSW]  <= mp_rdata;
            regs_r[pss_pkg::IDX_PSW][pss_pkg::TM_BIT] <= pss_pkg::TM_CLEAR;
          end
        end
        ST_LD_PC: if (fin) regs_r[pss_pkg::IDX_PC] <= mp_rdata;
        ST_LD_SP: begin
          if (fin) begin
            regs_r[pss_pkg::IDX_SP] <= mp_rdata;
            regs_r[pss_pkg::IDX_PSW] <= set_fields(
              regs_r[pss_pkg::IDX_PSW], pss_pkg::ISC_LOAD,
              pss_pkg::ET_LOAD);
            // Return never adjusts for an initial context
            if (!is_ret_r && regs_r[pss_pkg::IDX_PSW][pss_pkg::I_BIT]) begin
              regs_r[pss_pkg::IDX_PSW][pss_pkg::I_BIT] <= 1'b0;
              regs_r[pss_pkg::IDX_CONTROL_BLOCK_POINTER] <= tempa_r
                                           + pss_pkg::CTX_BYTES;
            end
          end
        end
        ST_BM_CNT: if (fin) regs_r[pss_pkg::IDX_R1] <= mp_rdata;
        ST_BM_SRC: if (fin) regs_r[pss_pkg::IDX_R0] <= mp_rdata;
        ST_BM_DST: if (fin) regs_r[pss_pkg::IDX_R2] <= mp_rdata;
        ST_BM_WR: begin
          if (fin) begin
            regs_r[pss_pkg::IDX_R0] <= regs_r[pss_pkg::IDX_R0]
                                       + pss_pkg::WORD_BYTES;
            regs_r[pss_pkg::IDX_R2] <= regs_r[pss_pkg::IDX_R2]
                                       + pss_pkg::WORD_BYTES;
            regs_r[pss_pkg::IDX_R1] <= regs_r[pss_pkg::IDX_R1] - 32'h1;
          end
        end
        ST_RS_GR: if (fin) regs_r[gr_idx_r] <= mp_rdata;
        default: ;
      endcase
    end
  end

  // Forced kernel level, busy and exception report
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_kernel_r <= 1'b0;
      switch_busy    <= 1'b0;
      exc_valid      <= 1'b0;
      exc_code       <= pss_pkg::EXC_NONE;
    end else begin
      exc_valid <= 1'b0;
      if (state_r == ST_IDLE && (go_call || go_ret)) begin
        if (kernel_now) begin
          force_kernel_r <= 1'b1;
          // Held high for the whole switch: interrupts wait
          switch_busy    <= 1'b1;
          exc_code       <= pss_pkg::EXC_NONE;
        end else begin
          exc_valid <= 1'b1;
          exc_code  <= pss_pkg::EXC_PRIV;
        end
      end
      if (mp_done && mp_fault) begin
        exc_valid <= 1'b1;
        case (state_r)
          ST_PUSH, ST_POP: exc_code <= pss_pkg::EXC_RST_ISTK;
          ST_SV_PSW, ST_SV_PC, ST_SV_SP, ST_SV_GR:
            exc_code <= pss_pkg::EXC_OLD_PCB;
          default: exc_code <= pss_pkg::EXC_NEW_PCB;
        endcase
      end
      if (state_r == ST_DONE) begin
        force_kernel_r <= 1'b0;
        switch_busy    <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: pss_switch_seq_sva.sv
// Port assertions for the process switch sequencer
`timescale 1ns/1ns
`default_nettype none
module pss_switch_seq_sva (
  // Clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // Watched ports
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire pss_pkg::pss_mem_req_t mem_req,
  input wire pss_pkg::pss_mem_rsp_t mem_rsp,
  input wire logic                  switch_busy,
  input wire logic                  exc_valid,
  input wire pss_pkg::pss_exc_t     exc_code
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  kernel_forced_a: assert property (mem_req.valid |-> mem_req.kernel)
    else $error("request without forced kernel");
  busy_inhibit_a: assert property (mem_req.valid |-> switch_busy)
    else $error("request outside a switch");
  start_req_a: assert property ($rose(switch_busy)
    |-> ##[0:6] mem_req.valid) else $error("switch without traffic");
  exc_pulse_a: assert property (exc_valid |=> !exc_valid)
    else $error("exception pulse too long");
  exc_code_a: assert property (exc_valid |-> exc_code != 3'h0)
    else $error("exception without code");
  busy_release_a: assert property (exc_valid |-> ##[0:3] !switch_busy)
    else $error("switch not ended after fault");
  req_hold_a: assert property (mem_req.valid && !mem_rsp.ack
    |=> $stable(mem_req)) else $error("request changed before ack");
  ack_drop_a: assert property (mem_rsp.ack |=> !mem_req.valid)
    else $error("request kept after ack");
  ahb_wait_a: assert property (!hreadyout |=> hreadyout && !hresp)
    else $error("bus wait too long or not okay");
  cover property (exc_valid && exc_code == pss_pkg::EXC_OLD_PCB);
  cover property (exc_valid && exc_code == pss_pkg::EXC_PRIV);
  cover property ($fell(switch_busy) && !exc_valid);
endmodule
bind pss_switch_seq pss_switch_seq_sva chk_u (.hclk, .hresetn, .hreadyout,
  .hresp, .mem_req, .mem_rsp, .switch_busy, .exc_valid, .exc_code);
`default_nettype wire

// File: tb.sv
// Self-checking bench for the process switch sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hwrite = 1'b0;
  logic        slow = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] bad = 32'hffff_fff0;
  logic [31:0] rd, hrdata;
  logic        hreadyout, hresp, switch_busy, exc_valid;
  pss_pkg::pss_mem_req_t mem_req;
  pss_pkg::pss_mem_rsp_t mem_rsp;
  pss_pkg::pss_exc_t     exc_code;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #20 hclk = ~hclk;
  pss_switch_seq dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(pss_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .mem_req, .mem_rsp, .switch_busy,
    .exc_valid, .exc_code);
  pss_mem_model mem_u (.hclk, .hresetn, .slow, .bad_addr(bad),
    .req(mem_req), .rsp(mem_rsp));
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= pss_pkg::HTRANS_NSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic go(input logic [31:0] c);
    bus(1'b1, 32'h40, c);
    repeat (3) @(posedge hclk);
    while (switch_busy !== 1'b0) @(posedge hclk);
  endtask
  task automatic ctx(input logic [31:0] processor_status_word, r0);
    bus(1'b1, 32'h2c, processor_status_word);
    bus(1'b1, 32'h38, 32'h2000);
    bus(1'b1, 32'h3c, 32'h3000);
    bus(1'b1, 32'h30, 32'h100);
    bus(1'b1, 32'h34, 32'h500);
    bus(1'b1, 32'h0, r0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude;
    end
  end
  initial begin
    logic [31:0] fa [3] = '{32'h3000, 32'h2000, 32'h1000};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    mem_u.mem[32'h1000] = 32'h8086;
    mem_u.mem[32'h1004] = 32'h4000;
    mem_u.mem[32'h1008] = 32'h6000;
    ctx(32'h8078, 32'h1000);
    go(32'h1);
    check(mem_u.mem[32'h3000], 32'h2000);
    check(mem_u.mem[32'h2000], 32'h8001);
    check(mem_u.mem[32'h2004], 32'h102);
    check(32'(mem_u.mem.exists(32'h2014)), 32'h0);
    rchk(32'h2c, 32'h803b);
    rchk(32'h38, 32'h100c);
    rchk(32'h34, 32'h6000);
    rchk(32'h3c, 32'h3004);
    go(32'h2);
    check(32'(mem_u.mem.exists(32'h100c)), 32'h0);
    rchk(32'h38, 32'h2000);
    rchk(32'h30, 32'h102);
    rchk(32'h3c, 32'h3000);
    // Register-saving call that moves one two-word block
    mem_u.mem[32'h5000] = 32'h100;
    mem_u.mem[32'h5040] = 32'h2;
    mem_u.mem[32'h5044] = 32'h7000;
    mem_u.mem[32'h5048] = 32'h7100;
    mem_u.mem[32'h504c] = 32'h0;
    mem_u.mem[32'h7004] = 32'hbbbb;
    slow <= 1'b0;
    for (int i = 1; i < 11; i++) bus(1'b1, 32'(4 * i), 32'h5000 + i);
    ctx(32'h0, 32'h5000);
    go(32'h1);
    for (int i = 0; i < 11; i++)
      check(mem_u.mem[32'h2014 + 4 * i], 32'h5000 + i);
    check(mem_u.mem[32'h7104], 32'hbbbb);
    rchk(32'h4, 32'h0);
    for (int i = 0; i < 3; i++) begin
      bad <= fa[i];
      ctx(32'h0, 32'h1000);
      go(32'h1);
      check(32'(exc_code), 32'(i + 1));
    end
    rchk(32'h44, 32'hc);
    bus(1'b1, 32'h2c, 32'h600);
    go(32'h2);
    check(32'(exc_code), 32'h4);
    rchk(32'h80, 32'h0);
    conclude;
  end
endmodule
`default_nettype wire
